/* File: core/lbs_lock_set.sv */
// Lock-bit setting command handler: frame check, acceptance, flash write and status reply.
`timescale 1ns/100ps
`default_nettype none
module lbs_lock_set #(
    parameter logic [31:0] LOCK_BASE = lbs_pkg::LOCK_AREA_BASE,
    parameter int          DEPTH     = lbs_pkg::FIFO_DEPTH
) (
    input  wire logic                   clk_sys,
    input  wire logic                   reset_n,
    // Received byte stream from the link.
    input  wire logic [7:0]             rx_data,
    input  wire logic                   rx_valid,
    output logic                        rx_ready,
    // Reply byte stream to the link.
    output logic [7:0]                  tx_data,
    output logic                        tx_valid,
    input  wire logic                   tx_ready,
    // Acceptance inputs (pins, resynchronised here).
    input  wire logic                   lifecycle_state_ok,
    input  wire logic                   auth_level_one,
    input  wire logic                   auth_level_zero,
    // Flash sequencer interface.
    output lbs_pkg::lbs_flash_req_t     flash_req,
    output logic                        flash_req_valid,
    input  wire logic                   flash_req_ready,
    input  wire logic                   flash_done,
    input  wire logic                   flash_error,
    input  wire logic [31:0]            flash_status,
    input  wire logic [31:0]            flash_fail_addr,
    output logic                        busy
);
    typedef enum {
        LBS_IDLE,
        LBS_LEN_HI,
        LBS_LEN_LO,
        LBS_BODY,
        LBS_SUM,
        LBS_ETX,
        LBS_CHECK,
        LBS_WRITE,
        LBS_WAIT,
        LBS_REPLY
    } lbs_state_t;

    lbs_state_t          state;
    logic [7:0]          byte_in;
    logic                byte_valid;
    logic                byte_take;
    logic [7:0]          len_hi;
    logic [7:0]          len_lo;
    logic [15:0]         body_cnt;
    logic [7:0]          sum;
    logic                etx_ok;
    logic                cmd_ok;
    logic [7:0]          payload [lbs_pkg::PAYLOAD_BYTES];
    logic [4:0]          wr_idx;
    lbs_pkg::lbs_result_t result;
    lbs_pkg::lbs_result_t next_result;
    logic [3:0]          tx_idx;
    logic [7:0]          tx_sum;
    logic [1:0]          lc_sync;
    logic [1:0]          auth1_sync;
    logic [1:0]          auth0_sync;

    function automatic logic [7:0] word_byte(input logic [31:0] w, input logic [1:0] i);
        word_byte = w[8*(3-i) +: 8];
    endfunction : word_byte

    // -------------------------------------------------------------------------
    // Input buffering and pin synchronisers
    // -------------------------------------------------------------------------
    lbs_fifo #(
        .WIDTH (8),
        .DEPTH (DEPTH)
    ) u_rx_fifo (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .in_data   (rx_data),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .out_data  (byte_in),
        .out_valid (byte_valid),
        .out_ready (byte_take)
    );

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            lc_sync    <= 2'h0;
            auth1_sync <= 2'h0;
            auth0_sync <= 2'h0;
        end else begin
            lc_sync    <= {lc_sync[0], lifecycle_state_ok};
            auth1_sync <= {auth1_sync[0], auth_level_one};
            auth0_sync <= {auth0_sync[0], auth_level_zero};
        end
    end

    // Bytes are consumed only while idle or while a frame is being received; the FIFO holds them otherwise and stalls the link once full.
    assign byte_take = byte_valid && (state inside {LBS_IDLE, LBS_LEN_HI, LBS_LEN_LO, LBS_BODY, LBS_SUM, LBS_ETX});
    assign busy      = (state != LBS_IDLE);

    // -------------------------------------------------------------------------
    // Frame reception
    // -------------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            len_hi   <= 8'h00;
            len_lo   <= 8'h00;
            body_cnt <= 16'h0000;
            sum      <= 8'h00;
            etx_ok   <= 1'b0;
            cmd_ok   <= 1'b0;
        end else if (byte_take) begin
            case (state)
                LBS_LEN_HI: begin
                    len_hi <= byte_in;
                    sum    <= byte_in;
                end
                LBS_LEN_LO: begin
                    len_lo   <= byte_in;
                    sum      <= sum + byte_in;
                    body_cnt <= 16'h0000;
                end
                LBS_BODY: begin
                    if (body_cnt == 16'h0000) begin
                        cmd_ok <= (byte_in == lbs_pkg::CMD_LOCK_SET);
                    end
                    sum      <= sum + byte_in;
                    body_cnt <= body_cnt + 16'h0001;
                end
                LBS_SUM: begin
                    sum <= sum + byte_in;
                end
                LBS_ETX: begin
                    etx_ok <= (byte_in == lbs_pkg::END_TEXT);
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (byte_take && state == LBS_BODY && body_cnt != 16'h0000 &&
            body_cnt <= 16'(lbs_pkg::PAYLOAD_BYTES)) begin
            payload[body_cnt[4:0] - 5'h01] <= byte_in;
        end
    end

    // -------------------------------------------------------------------------
    // Error priority
    // -------------------------------------------------------------------------
    always_comb begin
        next_result = '{status: lbs_pkg::STATUS_OK, detail: lbs_pkg::UNUSED_WORD,
                        fail_addr: lbs_pkg::UNUSED_WORD};
        if (!etx_ok) begin
            next_result.status = lbs_pkg::STATUS_PACKET;
        end else if (sum != 8'h00) begin
            next_result.status = lbs_pkg::STATUS_CHECKSUM;
        end else if ({len_hi, len_lo} == 16'h0000 || {len_hi, len_lo} > lbs_pkg::MAX_FRAME_LEN) begin
            next_result.status = lbs_pkg::STATUS_PACKET;
        end else if (len_hi != lbs_pkg::CMD_LEN_HIGH || len_lo != lbs_pkg::CMD_LEN_LOW || !cmd_ok) begin
            next_result.status = lbs_pkg::STATUS_PACKET;
        end else if (!lc_sync[1]) begin
            next_result.status = lbs_pkg::STATUS_ACCEPT;
        end else if (auth1_sync[1] || auth0_sync[1]) begin
            next_result.status = lbs_pkg::STATUS_SECURE;
        end
    end

    // -------------------------------------------------------------------------
    // Control sequence
    // -------------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state  <= LBS_IDLE;
            wr_idx <= 5'h00;
            result <= '{status: lbs_pkg::STATUS_OK, detail: lbs_pkg::UNUSED_WORD,
                        fail_addr: lbs_pkg::UNUSED_WORD};
            tx_idx <= 4'h0;
        end else begin
            case (state)
                LBS_IDLE: begin
                    if (byte_take && byte_in == lbs_pkg::START_HEADER) begin
                        state <= LBS_LEN_HI;
                    end
                end
                LBS_LEN_HI: begin
                    if (byte_take) begin
                        state <= LBS_LEN_LO;
                    end
                end
                LBS_LEN_LO: begin
                    if (byte_take) begin
                        state <= ({byte_in, len_hi} == 16'h0000) ? LBS_SUM : LBS_BODY;
                        // Frames beyond the tolerated length are cut short and fail as packet errors.
                        if ({len_hi, byte_in} == 16'h0000 || {len_hi, byte_in} > lbs_pkg::MAX_FRAME_LEN) begin
                            state <= LBS_SUM;
                        end
                    end
                end
                LBS_BODY: begin
                    if (byte_take && body_cnt + 16'h0001 == {len_hi, len_lo}) begin
                        state <= LBS_SUM;
                    end
                end
                LBS_SUM: begin
                    if (byte_take) begin
                        state <= LBS_ETX;
                    end
                end
                LBS_ETX: begin
                    if (byte_take) begin
                        state <= LBS_CHECK;
                    end
                end
                LBS_CHECK: begin
                    result <= next_result;
                    wr_idx <= 5'h00;
                    tx_idx <= 4'h0;
                    state  <= (next_result.status == lbs_pkg::STATUS_OK) ? LBS_WRITE : LBS_REPLY;
                end
                LBS_WRITE: begin
                    if (flash_req_ready) begin
                        state <= LBS_WAIT;
                    end
                end
                LBS_WAIT: begin
                    if (flash_done) begin
                        if (flash_error) begin
                            result <= '{status: lbs_pkg::STATUS_FLASH, detail: flash_status,
                                        fail_addr: flash_fail_addr};
                            state  <= LBS_REPLY;
                        end else if (wr_idx == 5'(lbs_pkg::PAYLOAD_BYTES - 1)) begin
                            state <= LBS_REPLY;
                        end else begin
                            wr_idx <= wr_idx + 5'h01;
                            state  <= LBS_WRITE;
                        end
                    end
                end
                LBS_REPLY: begin
                    if (tx_ready) begin
                        if (tx_idx == 4'(lbs_pkg::RESP_BYTES - 1)) begin
                            state <= LBS_IDLE;
                        end else begin
                            tx_idx <= tx_idx + 4'h1;
                        end
                    end
                end
                default: begin
                    state <= LBS_IDLE;
                end
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // Flash write request
    // -------------------------------------------------------------------------
    // payload bits passed unaltered
    // sequencer only clears bits; a one never overrides a zero
    // no error raised for such bytes
    assign flash_req_valid = (state == LBS_WRITE);
    always_comb begin
        flash_req.addr      = LOCK_BASE + 32'(wr_idx);
        flash_req.data      = payload[wr_idx];
        flash_req.keep_mask = 8'h00;
        // last byte bits seven and six kept
        if (wr_idx == 5'(lbs_pkg::PAYLOAD_BYTES - 1)) begin
            flash_req.keep_mask = lbs_pkg::LAST_KEEP_MASK;
        end
    end

    // -------------------------------------------------------------------------
    // Reply frame
    // -------------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tx_sum <= 8'h00;
        end else if (state != LBS_REPLY) begin
            tx_sum <= 8'h00;
        end else if (tx_ready && tx_idx != 4'h0) begin
            tx_sum <= tx_sum + tx_data;
        end
    end

    always_comb begin
        tx_data = 8'h00;
        case (tx_idx)
            4'h0: tx_data = lbs_pkg::START_DATA;
            4'h1: tx_data = lbs_pkg::RESP_LEN_HIGH;
            4'h2: tx_data = lbs_pkg::RESP_LEN_LOW;
            4'h3: tx_data = (result.status == lbs_pkg::STATUS_OK) ? lbs_pkg::RESP_OK : lbs_pkg::RESP_ERR;
            4'h4: tx_data = result.status;
            4'h5, 4'h6, 4'h7, 4'h8: tx_data = word_byte(result.detail, 2'(tx_idx - 4'h5));
            4'h9, 4'hA, 4'hB, 4'hC: tx_data = word_byte(result.fail_addr, 2'(tx_idx - 4'h9));
            4'hD: tx_data = 8'h00 - tx_sum;
            4'hE: tx_data = lbs_pkg::END_TEXT;
            default: tx_data = 8'h00;
        endcase
    end
    assign tx_valid = (state == LBS_REPLY);
endmodule : lbs_lock_set
`default_nettype wire

/* File: include/lbs_pkg.sv */
// Package of constants and carrier types for the lock-bit setting command handler.
`default_nettype none
package lbs_pkg;
    // -------------------------------------------------------------------------
    // Frame bytes
    // -------------------------------------------------------------------------
    localparam logic [7:0] START_HEADER   = 8'h01;
    localparam logic [7:0] START_DATA     = 8'h81;
    localparam logic [7:0] END_TEXT       = 8'h03;
    localparam logic [7:0] CMD_LOCK_SET   = 8'h4A;
    localparam logic [7:0] RESP_OK        = 8'h4A;
    localparam logic [7:0] RESP_ERR       = 8'hCA;
    localparam logic [7:0] CMD_LEN_HIGH   = 8'h00;
    localparam logic [7:0] CMD_LEN_LOW    = 8'h13;
    localparam logic [7:0] RESP_LEN_HIGH  = 8'h00;
    localparam logic [7:0] RESP_LEN_LOW   = 8'h0A;
    localparam int         PAYLOAD_BYTES  = 18;
    localparam int         RESP_BYTES     = 15;
    // Largest length field a frame may carry, and the longest frame tolerated.
    localparam logic [15:0] MAX_FRAME_LEN = 16'h0400;
    // -------------------------------------------------------------------------
    // Status codes
    // -------------------------------------------------------------------------
    localparam logic [7:0]  STATUS_OK       = 8'h00;
    localparam logic [7:0]  STATUS_PACKET   = 8'hC1;
    localparam logic [7:0]  STATUS_CHECKSUM = 8'hC2;
    localparam logic [7:0]  STATUS_ACCEPT   = 8'hC3;
    localparam logic [7:0]  STATUS_SECURE   = 8'hC4;
    localparam logic [7:0]  STATUS_FLASH    = 8'hE1;
    localparam logic [31:0] UNUSED_WORD   = 32'hFFFFFFFF;
    // Bits of the last payload byte that guard the key hash and stay untouched.
    localparam logic [7:0]  LAST_KEEP_MASK = 8'hC0;
    localparam logic [31:0] LOCK_AREA_BASE = 32'h00000000;
    localparam int          FIFO_DEPTH     = 16;

    typedef struct packed {
        logic [7:0]  status;
        logic [31:0] detail;
        logic [31:0] fail_addr;
    } lbs_result_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [7:0]  data;
        logic [7:0]  keep_mask;
    } lbs_flash_req_t;
endpackage : lbs_pkg
`default_nettype wire

/* File: core/lbs_fifo.sv */
// Parameterised valid/ready FIFO buffering received command bytes.
`timescale 1ns/100ps
`default_nettype none
module lbs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : lbs_fifo
`default_nettype wire

/* File: tb/lbs_checker.sv */
// Port assertions for the lock-bit setting command handler.
`timescale 1ns/100ps
`default_nettype none
module lbs_checker #(
    parameter logic [31:0] LOCK_BASE = 32'h00000000
) (
    input wire logic                    clk_sys,
    input wire logic                    reset_n,
    input wire logic [7:0]              tx_data,
    input wire logic                    tx_valid,
    input wire logic                    tx_ready,
    input wire lbs_pkg::lbs_flash_req_t flash_req,
    input wire logic                    flash_req_valid,
    input wire logic                    flash_req_ready,
    input wire logic                    flash_done,
    input wire logic                    flash_error,
    input wire logic                    busy
);
    logic [4:0] wr_cnt;
    logic [3:0] tx_cnt;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // ----
    // Counters of writes per command and bytes per reply.
    // ----
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wr_cnt <= 5'h00;
        end else if (!busy) begin
            wr_cnt <= 5'h00;
        end else if (flash_req_valid && flash_req_ready) begin
            wr_cnt <= wr_cnt + 5'h01;
        end
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tx_cnt <= 4'h0;
        end else if (!tx_valid) begin
            tx_cnt <= 4'h0;
        end else if (tx_ready) begin
            tx_cnt <= tx_cnt + 4'h1;
        end
    end
    a_addr_ascend: assert property (flash_req_valid |-> flash_req.addr == LOCK_BASE + 32'(wr_cnt))
        else $error("write address out of order");
    a_key_bits_kept: assert property (flash_req_valid |->
        flash_req.keep_mask == ((wr_cnt == 5'h11) ? 8'hC0 : 8'h00)) else $error("wrong keep mask");
    a_req_holds: assert property (flash_req_valid && !flash_req_ready |=> flash_req_valid && $stable(flash_req))
        else $error("write request dropped or changed");
    a_tx_holds: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte dropped or changed");
    a_reply_head: assert property ($rose(tx_valid) |-> tx_data == 8'h81)
        else $error("reply does not open with start of data");
    a_reply_tail: assert property (tx_valid && tx_ready && tx_cnt == 4'hE |-> tx_data == 8'h03 ##1 !tx_valid)
        else $error("reply not fifteen bytes ending in terminator");
    a_no_overlap: assert property (tx_valid |-> !flash_req_valid)
        else $error("write during reply");
    a_flash_reply: assert property (flash_done && flash_error |-> ##[1:16] tx_valid)
        else $error("no reply after flash failure");
    a_fail_stops: assert property (flash_done && flash_error |=> !flash_req_valid [*8])
        else $error("writes continue after flash failure");
    a_busy_flag: assert property (tx_valid || flash_req_valid |-> busy)
        else $error("busy low while active");
    c_flash_fail: cover property (flash_done && flash_error);
    c_last_write: cover property (flash_req_valid && flash_req_ready && wr_cnt == 5'h11);
    c_reply_end: cover property (tx_valid && tx_ready && tx_cnt == 4'hE);
endmodule : lbs_checker
`default_nettype wire

/* File: tb/lbs_host_model.sv */
// Host tool model: sends queued bytes and collects reply bytes with random stalls.
`timescale 1ns/100ps
`default_nettype none
module lbs_host_model (
    input wire logic        clk_sys,
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    input wire logic        rx_ready,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_valid,
    output logic            tx_ready
);
    logic [7:0] send_q[$];
    logic [7:0] recv_q[$];
    integer     seed = 5;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b0;
    end
    always @(posedge clk_sys) begin
        if (rx_valid && rx_ready) void'(send_q.pop_front());
        if (tx_valid && tx_ready) recv_q.push_back(tx_data);
    end
    // Idle data toggles so that a stale byte can never look valid.
    always @(negedge clk_sys) begin
        rx_valid <= (send_q.size() != 0);
        rx_data <= (send_q.size() != 0) ? send_q[0] : ~rx_data;
        tx_ready <= ($random(seed) % 3) != 0;
    end
endmodule : lbs_host_model
`default_nettype wire

/* File: tb/test_lock_bit_setting_command.sv */
// Self-checking bench for the lock-bit setting command handler.
`timescale 1ns/100ps
`default_nettype none
module test_lock_bit_setting_command;
    localparam logic [31:0] LOCK_BASE = 32'h00000100;
    logic clk_sys, reset_n, rx_valid, rx_ready, tx_valid, tx_ready, busy;
    logic lifecycle_state_ok, auth_level_one, auth_level_zero, saw_full = 1'b0;
    logic flash_req_valid, flash_req_ready, flash_done, flash_error;
    logic [7:0] rx_data, tx_data, mem[18], pay[18], exp_mem[18];
    logic [31:0] flash_status, flash_fail_addr;
    lbs_pkg::lbs_flash_req_t flash_req;
    logic [7:0] status_tab[8] = '{lbs_pkg::STATUS_PACKET, lbs_pkg::STATUS_CHECKSUM, lbs_pkg::STATUS_PACKET,
        lbs_pkg::STATUS_PACKET, lbs_pkg::STATUS_PACKET, lbs_pkg::STATUS_ACCEPT, lbs_pkg::STATUS_SECURE,
        lbs_pkg::STATUS_SECURE};
    int mismatches = 0, tests_run = 0, wr_n = 0, w0 = 0, fail_at = -1, fl_wait = 0, cyc = 0, k;
    integer seed = 5;
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    lbs_lock_set #(.LOCK_BASE(LOCK_BASE)) u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .lifecycle_state_ok(lifecycle_state_ok), .auth_level_one(auth_level_one), .auth_level_zero(auth_level_zero),
        .flash_req(flash_req), .flash_req_valid(flash_req_valid), .flash_req_ready(flash_req_ready),
        .flash_done(flash_done), .flash_error(flash_error), .flash_status(flash_status),
        .flash_fail_addr(flash_fail_addr), .busy(busy));
    lbs_host_model u_host (.clk_sys(clk_sys), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
    // ----
    // Flash sequencer stand-in: programming only clears bits, as real flash does.
    // ----
    always @(posedge clk_sys) begin
        if (rx_valid && !rx_ready) saw_full = 1'b1;
        if (flash_req_valid && flash_req_ready) begin
            mem[flash_req.addr - LOCK_BASE] <= mem[flash_req.addr - LOCK_BASE] & (flash_req.data | flash_req.keep_mask);
            wr_n++;
            fl_wait = 3;
        end
    end
    always @(negedge clk_sys) begin
        flash_req_ready <= flash_req_valid && fl_wait == 0 && !flash_req_ready;
        flash_done <= (fl_wait == 1);
        flash_error <= (fl_wait == 1) && (wr_n == fail_at);
        if (fl_wait > 0) fl_wait--;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            end_sim();
        end
    end
    // ----
    // Checking and stimulus tasks
    // ----
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic end_sim;
        if (mismatches == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim
    function automatic logic [119:0] reply(input logic [7:0] status, input logic [31:0] det, input logic [31:0] adr);
        logic [7:0] code;
        logic [7:0] s;
        code = (status == 8'h00) ? 8'h4A : 8'hCA;
        s = 8'h0A + code + status;
        for (int i = 0; i < 4; i++) s = s + det[8*i+:8] + adr[8*i+:8];
        return {8'h81, 8'h00, 8'h0A, code, status, det, adr, 8'h00 - s, 8'h03};
    endfunction : reply
    task automatic send(input logic [7:0] lh, ll, input int nb, input logic [7:0] sd, et);
        logic [7:0] s;
        logic [7:0] b;
        s = lh + ll;
        u_host.send_q.push_back(8'h01);
        u_host.send_q.push_back(lh);
        u_host.send_q.push_back(ll);
        for (int i = 0; i < nb; i++) begin
            b = (i == 0) ? 8'h4A : pay[i-1];
            s = s + b;
            u_host.send_q.push_back(b);
        end
        u_host.send_q.push_back(8'h00 - s + sd);
        u_host.send_q.push_back(et);
    endtask : send
    task automatic expect_reply(input logic [7:0] status, input logic [31:0] det, adr, input int nw);
        logic [119:0] e;
        int n;
        e = reply(status, det, adr);
        n = 0;
        while (u_host.recv_q.size() < 15 && n < 4000) begin
            @(negedge clk_sys);
            n++;
        end
        check(u_host.recv_q.size() >= 15, 1);
        for (int i = 0; i < 15 && u_host.recv_q.size() > 0; i++) check(u_host.recv_q.pop_front(), e[119-8*i-:8]);
        check(wr_n - w0, nw);
        w0 = wr_n;
    endtask : expect_reply
    task automatic ok_run(input int frames);
        for (int i = 0; i < 18; i++) exp_mem[i] = mem[i] & (pay[i] | ((i == 17) ? 8'hC0 : 8'h00));
        for (int f = 0; f < frames; f++) send(8'h00, 8'h13, 19, 8'h00, 8'h03);
        for (int f = 0; f < frames; f++) expect_reply(8'h00, 32'hFFFFFFFF, 32'hFFFFFFFF, 18);
        for (int i = 0; i < 18; i++) check(mem[i], exp_mem[i]);
    endtask : ok_run
    initial begin
        reset_n = 1'b0;
        lifecycle_state_ok = 1'b1;
        auth_level_one = 1'b0;
        auth_level_zero = 1'b0;
        flash_status = 32'h00000000;
        flash_fail_addr = 32'h00000000;
        for (int i = 0; i < 18; i++) mem[i] = 8'hFF;
        repeat (3) @(negedge clk_sys);
        reset_n = 1'b1;
        // Noise ahead of the first header must be skipped.
        u_host.send_q.push_back(8'h80 | 8'($random(seed)));
        u_host.send_q.push_back(8'h03);
        for (int r = 0; r < 3; r++) begin
            for (int i = 0; i < 18; i++) pay[i] = 8'($random(seed));
            ok_run(r + 1);
        end
        check(saw_full, 1);
        for (int i = 0; i < 18; i++) pay[i] = 8'hFF;
        ok_run(1);
        for (int j = 0; j < 8; j++) begin
            lifecycle_state_ok = (j != 5);
            auth_level_one = (j == 5 || j == 6);
            auth_level_zero = (j == 7);
            repeat (4) @(negedge clk_sys);
            case (j)
                0: send(8'h00, 8'h13, 19, 8'h01, 8'h55);
                1: send(8'h00, 8'h13, 19, 8'h01, 8'h03);
                2: send(8'h00, 8'h00, 0, 8'h00, 8'h03);
                3: send(8'h05, 8'h00, 0, 8'h00, 8'h03);
                4: send(8'h00, 8'h12, 18, 8'h00, 8'h03);
                default: send(8'h00, 8'h13, 19, 8'h00, 8'h03);
            endcase
            expect_reply(status_tab[j], 32'hFFFFFFFF, 32'hFFFFFFFF, 0);
        end
        lifecycle_state_ok = 1'b1;
        auth_level_one = 1'b0;
        auth_level_zero = 1'b0;
        k = 1 + ({$random(seed)} % 18);
        fail_at = wr_n + k;
        flash_status = $random(seed);
        flash_fail_addr = $random(seed);
        send(8'h00, 8'h13, 19, 8'h00, 8'h03);
        expect_reply(lbs_pkg::STATUS_FLASH, flash_status, flash_fail_addr, k);
        fail_at = -1;
        ok_run(1);
        end_sim();
    end
endmodule : test_lock_bit_setting_command
bind lbs_lock_set lbs_checker #(.LOCK_BASE(LOCK_BASE)) u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .flash_req(flash_req),
    .flash_req_valid(flash_req_valid), .flash_req_ready(flash_req_ready), .flash_done(flash_done),
    .flash_error(flash_error), .busy(busy));
`default_nettype wire
